// ### fac_capture_model.sv
// capture-side model that drives the conversion clock in pulse sequences
`timescale 1ns/10ps
module fac_capture_model (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [1:0] i_mode,
  input wire logic i_phase_invert,
  output logic o_conv_clock,
  output logic o_busy
);
  logic [7:0] pat_r;
  logic [3:0] cnt_r;
  logic idle_r;
  logic acq;
  assign acq = o_busy ? pat_r[0] : idle_r;
  assign o_busy = (cnt_r != 4'h0);
  assign o_conv_clock = ~(acq ^ i_phase_invert);
  always_ff @(negedge i_clock) begin
    if (!i_reset_n) begin
      cnt_r <= 4'h0;
      pat_r <= 8'h00;
      idle_r <= 1'b1;
    end else if (i_start) begin
      cnt_r <= 4'h8;
      idle_r <= (i_mode != 2'h2);
      case (i_mode)
        2'h1: pat_r <= 8'hf3;
        2'h2: pat_r <= 8'h33;
        2'h3: pat_r <= 8'hcc;
        default: pat_r <= 8'haa;
      endcase
    end else if (o_busy) begin
      pat_r <= {1'b0, pat_r[7:1]};
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : fac_capture_model

// ### fac_conv_if.sv
// carrier between sequencer, decode array and output register
`timescale 1ns/10ps
interface fac_conv_if;
  import fac_pkg::*;

  logic [COMPARATOR_COUNT-1:0] latched;
  logic [RESULT_WIDTH-1:0] result;
  logic load;
  logic clock_enable;
  logic data_enable_n;
  logic all_outputs_enable;

  modport dec (input latched, output result);
  modport drive (output latched, load, clock_enable, data_enable_n, all_outputs_enable,
                 input result);
  modport sink (input result, load, clock_enable, data_enable_n, all_outputs_enable);

endinterface : fac_conv_if

// ### fac_decoder.sv
// decode array from latched comparator states to seven-bit result
`timescale 1ns/10ps
module fac_decoder
  import fac_pkg::*;
(
  fac_conv_if.dec conv
);

  // lsb on bit 0, overflow on the top bit
  assign conv.result = thermometer_to_code(conv.latched);

endmodule : fac_decoder

// ### fac_flash_adc_timing.sv
// conversion phase sequencer for a six-bit flash converter with overflow
`timescale 1ns/10ps
// Contract
// - one conversion per conversion clock period
// - select low: balance high, acquire low
// - select high complements clock into the chip
// - latch 64 states, decode, load on acquire start
// - data enable high floats code, overflow driven
// - all-outputs enable low floats every output
// - select high: latches track whole high level
// - falling edge freezes latches, balance begins
// - next rising edge loads result, new acquire
// - single balance pulse: capture, then load
// - two balance pulses: data after two cycles
// - lowest code bit carries the lsb
module fac_flash_adc_timing
  import fac_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clock_enable,
  input wire logic i_conv_clock,
  input wire logic i_phase_invert,
  input wire logic [COMPARATOR_COUNT-1:0] i_comparators,
  input wire logic i_data_enable_n,
  input wire logic i_all_outputs_enable,
  output logic [CODE_WIDTH-1:0] o_code_bits,
  output logic o_code_bits_oe,
  output logic o_overflow_bit,
  output logic o_overflow_bit_oe,
  output logic o_code_valid,
  output logic o_droop_expired,
  output logic o_acquire_phase
);

  fac_conv_if conv ();

  fac_phase_type phase_r;
  fac_phase_type phase_nxt;
  logic [COMPARATOR_COUNT-1:0] latch_r;
  logic [COMPARATOR_COUNT-1:0] latch_nxt;
  logic captured_r;
  logic valid_r;
  logic valid_nxt;
  logic [HOLD_WIDTH-1:0] hold_r;
  logic [HOLD_WIDTH-1:0] hold_nxt;
  logic droop_r;
  logic droop_nxt;

  // phase decode from the incoming conversion clock
  wire logic acquire_w = ~(i_conv_clock ^ i_phase_invert);
  wire logic in_acquire_w = (phase_r == PH_ACQUIRE);
  wire logic acquire_start_w = i_clock_enable & ~in_acquire_w & acquire_w;
  wire logic acquire_end_w = i_clock_enable & in_acquire_w & ~acquire_w;
  wire logic track_w = i_clock_enable & acquire_w;

  // latches follow comparators while acquiring and hold otherwise
  assign latch_nxt = track_w ? i_comparators : latch_r;

  // one load per acquire start: covers continuous and all pulse sequences
  assign conv.load = acquire_start_w;
  assign conv.latched = latch_r;
  assign conv.clock_enable = i_clock_enable;
  assign conv.data_enable_n = i_data_enable_n;
  assign conv.all_outputs_enable = i_all_outputs_enable;

  // result is valid only once a frozen sample has been loaded
  assign valid_nxt = valid_r | (acquire_start_w & captured_r);

  // acquire hold time, compared with the capacitor droop limit
  wire logic hold_sat_w = (hold_r == HOLD_LIMIT);
  assign hold_nxt = acquire_start_w ? HOLD_RESET :
                    (acquire_w && !hold_sat_w) ? hold_r + 10'h001 : hold_r;
  assign droop_nxt = acquire_start_w ? 1'b0 : (droop_r | (acquire_w & hold_sat_w));

  always_comb begin
    case (phase_r)
      PH_BALANCE: begin
        phase_nxt = acquire_w ? PH_ACQUIRE : PH_BALANCE;
      end
      PH_ACQUIRE: begin
        phase_nxt = acquire_w ? PH_ACQUIRE : PH_BALANCE;
      end
      default: begin
        phase_nxt = PH_BALANCE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      phase_r <= PH_BALANCE;
      latch_r <= LATCH_RESET;
      captured_r <= 1'b0;
      valid_r <= 1'b0;
    end else if (i_clock_enable) begin
      phase_r <= phase_nxt;
      latch_r <= latch_nxt;
      captured_r <= captured_r | acquire_end_w;
      valid_r <= valid_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      hold_r <= HOLD_RESET;
      droop_r <= 1'b0;
    end else if (i_clock_enable) begin
      hold_r <= hold_nxt;
      droop_r <= droop_nxt;
    end
  end

  fac_decoder u_decoder (
    .conv (conv)
  );

  fac_output_stage u_output_stage (
    .i_clock (i_clock),
    .i_reset_n (i_reset_n),
    .conv (conv),
    .o_code_bits (o_code_bits),
    .o_code_bits_oe (o_code_bits_oe),
    .o_overflow_bit (o_overflow_bit),
    .o_overflow_bit_oe (o_overflow_bit_oe)
  );

  assign o_code_valid = valid_r;
  assign o_droop_expired = droop_r;
  assign o_acquire_phase = in_acquire_w;

  a_phase_map: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_clock_enable |=> (o_acquire_phase == ($past(i_conv_clock) == $past(i_phase_invert))))
    else $error("acquire phase does not follow clock and phase select");

  a_latch_track: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_enable && (i_conv_clock == i_phase_invert)) |=> (latch_r == $past(i_comparators)))
    else $error("latches did not track comparators during acquire");

  a_latch_freeze: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_enable && (i_conv_clock != i_phase_invert)) |=> $stable(latch_r))
    else $error("latches changed during balance phase");

  a_load_once: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    conv.load |=> !conv.load)
    else $error("two loads without a balance phase between them");

  a_load_on_start: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_enable && !o_acquire_phase && (i_conv_clock == i_phase_invert)) |-> conv.load)
    else $error("acquire start did not load the output register");

  a_continuous_two_cycles: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_enable ##1 acquire_end_w ##1 conv.load)
      |=> ({o_overflow_bit, o_code_bits} == thermometer_to_code($past(i_comparators, 3))))
    else $error("frozen sample not presented after the following acquire start");

  a_valid_first: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (!o_code_valid && !captured_r) |=> !o_code_valid)
    else $error("code marked valid before any sample was frozen");

  a_droop_flag: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_enable && acquire_w && !acquire_start_w && hold_sat_w) |=> o_droop_expired)
    else $error("droop limit passed without flagging");

  a_overflow_code: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (conv.latched == LATCH_RESET) |-> (conv.result == OVERFLOW_CODE))
    else $error("all comparators tripped but no overflow code");

  a_lsb_order: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    ($countones(conv.latched) == (COMPARATOR_COUNT - 1)) |-> (conv.result == 7'h01))
    else $error("single tripped comparator not on lowest code bit");

  a_freeze_phase: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_clock_enable |=> $stable(o_acquire_phase))
    else $error("phase moved while clock enable low");

  a_freeze_latch: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_clock_enable |=> $stable(latch_r))
    else $error("latches moved while clock enable low");

  a_freeze_valid: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_clock_enable |=> $stable(o_code_valid))
    else $error("valid flag moved while clock enable low");

  a_freeze_droop: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_clock_enable |=> $stable(o_droop_expired))
    else $error("droop flag moved while clock enable low");

  a_freeze_code: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_clock_enable |=> $stable({o_overflow_bit, o_code_bits}))
    else $error("output code moved while clock enable low");

  a_freeze_oe: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_clock_enable |=> $stable({o_code_bits_oe, o_overflow_bit_oe}))
    else $error("output enables moved while clock enable low");

  a_freeze_hold: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_clock_enable |=> $stable(hold_r))
    else $error("hold counter moved while clock enable low");

  a_load_needs_enable: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_clock_enable |-> !conv.load)
    else $error("load issued while clock enable low");

  a_load_not_acquiring: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_acquire_phase |-> !conv.load)
    else $error("load issued inside an acquire phase");

  a_load_not_balance: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_conv_clock != i_phase_invert) |-> !conv.load)
    else $error("load issued while clock level selects balance");

  a_code_stands: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_enable && !conv.load) |=> $stable({o_overflow_bit, o_code_bits}))
    else $error("output code changed without a load");

  a_valid_sticky: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_code_valid |=> o_code_valid)
    else $error("valid flag dropped without reset");

  a_valid_set: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (conv.load && captured_r) |=> o_code_valid)
    else $error("frozen sample loaded but valid flag not set");

  a_capture_on_end: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    acquire_end_w |=> captured_r)
    else $error("acquire end did not mark a frozen sample");

  a_phase_enter: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_enable && !o_acquire_phase && (i_conv_clock == i_phase_invert)) |=> o_acquire_phase)
    else $error("acquire phase not entered");

  a_phase_leave: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_enable && o_acquire_phase && (i_conv_clock != i_phase_invert)) |=> !o_acquire_phase)
    else $error("acquire phase not left on balance level");

  a_hold_clear: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    conv.load |=> (hold_r == HOLD_RESET))
    else $error("hold counter not cleared at acquire start");

  a_droop_clear: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    conv.load |=> !o_droop_expired)
    else $error("droop flag not cleared at acquire start");

  a_hold_bound: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    hold_r <= HOLD_LIMIT)
    else $error("hold counter ran past the droop limit");

  a_droop_sticky: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (o_droop_expired && !conv.load) |=> o_droop_expired)
    else $error("droop flag dropped before the next acquire start");

  a_droop_late: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (!o_droop_expired && !hold_sat_w) |=> !o_droop_expired)
    else $error("droop flag raised before the limit");

  a_zero_code: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (conv.latched == ~LATCH_RESET) |-> (conv.result == RESULT_RESET))
    else $error("no tripped comparator but nonzero code");

  a_code_range: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (conv.result <= 7'h3f) || (conv.result == OVERFLOW_CODE))
    else $error("decoded code outside the legal set");

  a_ovf_full: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    conv.result[OVERFLOW_POS] |-> (conv.result == OVERFLOW_CODE))
    else $error("overflow bit set without all code bits high");

  a_half_scale: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    ($countones(conv.latched) == 32) |-> (conv.result == 7'h20))
    else $error("half scale input not on the top code bit");

endmodule : fac_flash_adc_timing

// ### fac_output_stage.sv
// output registers and three-state enables for code and overflow
`timescale 1ns/10ps
module fac_output_stage
  import fac_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  fac_conv_if.sink conv,
  output logic [CODE_WIDTH-1:0] o_code_bits,
  output logic o_code_bits_oe,
  output logic o_overflow_bit,
  output logic o_overflow_bit_oe
);

  logic [RESULT_WIDTH-1:0] result_r;
  logic code_oe_r;
  logic ovf_oe_r;

  wire logic code_oe_nxt = conv.all_outputs_enable & ~conv.data_enable_n;
  wire logic ovf_oe_nxt = conv.all_outputs_enable;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      result_r <= RESULT_RESET;
      code_oe_r <= 1'b0;
      ovf_oe_r <= 1'b0;
    end else if (conv.clock_enable) begin
      if (conv.load) begin
        result_r <= conv.result;
      end
      code_oe_r <= code_oe_nxt;
      ovf_oe_r <= ovf_oe_nxt;
    end
  end

  assign o_code_bits = result_r[CODE_WIDTH-1:0];
  assign o_overflow_bit = result_r[OVERFLOW_POS];
  assign o_code_bits_oe = code_oe_r;
  assign o_overflow_bit_oe = ovf_oe_r;

  a_load_code: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (conv.clock_enable && conv.load) |=> ({o_overflow_bit, o_code_bits} == $past(conv.result)))
    else $error("output register did not take decoded result on load");

  a_data_tristate: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (conv.clock_enable && conv.data_enable_n) |=> !o_code_bits_oe)
    else $error("code bits driven while data enable is inactive");

  a_all_tristate: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (conv.clock_enable && !conv.all_outputs_enable) |=> (!o_code_bits_oe && !o_overflow_bit_oe))
    else $error("outputs driven while all-outputs enable is low");

  a_ovf_driven: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (conv.clock_enable && conv.all_outputs_enable) |=> o_overflow_bit_oe)
    else $error("overflow not driven with all-outputs enable high");

endmodule : fac_output_stage

// ### fac_pkg.sv
// shared constants, types and decode function for the flash converter sequencer
package fac_pkg;

  localparam int COMPARATOR_COUNT = 64;
  localparam int CODE_WIDTH = 6;
  localparam int RESULT_WIDTH = 7;
  localparam int OVERFLOW_POS = 6;
  localparam logic [RESULT_WIDTH-1:0] OVERFLOW_CODE = 7'h7f;
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 7'h00;
  localparam logic [COMPARATOR_COUNT-1:0] LATCH_RESET = 64'h0;
  localparam int CLOCK_MHZ = 125;
  localparam int DROOP_LIMIT_US = 5;
  localparam int DROOP_CYCLES = DROOP_LIMIT_US * CLOCK_MHZ;
  localparam int HOLD_WIDTH = 10;
  localparam logic [HOLD_WIDTH-1:0] HOLD_RESET = 10'h000;
  localparam logic [HOLD_WIDTH-1:0] HOLD_LIMIT = HOLD_WIDTH'(DROOP_CYCLES);

  typedef enum logic {
    PH_BALANCE,
    PH_ACQUIRE
  } fac_phase_type;

  // count of comparators whose tap lies below the input, overflow when all trip
  function automatic logic [RESULT_WIDTH-1:0] thermometer_to_code(
    input logic [COMPARATOR_COUNT-1:0] cmp
  );
    logic [RESULT_WIDTH-1:0] n;
    n = RESULT_RESET;
    for (int i = 0; i < COMPARATOR_COUNT; i++) begin
      n = n + RESULT_WIDTH'(~cmp[i]);
    end
    if (n == RESULT_WIDTH'(COMPARATOR_COUNT)) begin
      n = OVERFLOW_CODE;
    end
    return n;
  endfunction : thermometer_to_code

endpackage : fac_pkg

// ### testbench.sv
// self-checking bench for the flash converter sequencer
`timescale 1ns/10ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: %s", $time, m); end end
module testbench;
  import fac_pkg::*;
  logic i_clock, i_reset_n, i_clock_enable, i_phase_invert, i_data_enable_n;
  logic i_all_outputs_enable, start, busy, conv_clock;
  logic [1:0] mode;
  logic [63:0] i_comparators;
  logic [5:0] o_code_bits;
  logic o_code_bits_oe, o_overflow_bit, o_overflow_bit_oe, o_code_valid;
  logic o_droop_expired, o_acquire_phase;
  logic [6:0] last;
  int err_count = 0;
  int check_count = 0;
  fac_flash_adc_timing fac_flash_adc_timing_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_clock_enable(i_clock_enable), .i_conv_clock(conv_clock),
    .i_phase_invert(i_phase_invert), .i_comparators(i_comparators),
    .i_data_enable_n(i_data_enable_n), .i_all_outputs_enable(i_all_outputs_enable),
    .o_code_bits(o_code_bits), .o_code_bits_oe(o_code_bits_oe),
    .o_overflow_bit(o_overflow_bit), .o_overflow_bit_oe(o_overflow_bit_oe),
    .o_code_valid(o_code_valid), .o_droop_expired(o_droop_expired),
    .o_acquire_phase(o_acquire_phase));
  fac_capture_model fac_capture_model_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_start(start), .i_mode(mode), .i_phase_invert(i_phase_invert),
    .o_conv_clock(conv_clock), .o_busy(busy));
  always #4 i_clock = ~i_clock;
  function automatic logic [6:0] exp_code(input int n);
    return (n == 64) ? 7'h7f : 7'(n);
  endfunction : exp_code
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // one pulse-mode conversion of a thermometer input with n tripped taps
  task automatic convert(input int n, input logic [1:0] m);
    int k;
    logic [6:0] e;
    e = exp_code(n);
    @(negedge i_clock);
    i_comparators <= 64'hffffffffffffffff << n;
    i_phase_invert <= 1'($urandom);
    i_data_enable_n <= 1'($urandom);
    i_all_outputs_enable <= 1'($urandom);
    mode <= m;
    repeat (2) @(negedge i_clock);
    start <= 1'b1;
    @(negedge i_clock);
    start <= 1'b0;
    @(negedge i_clock);
    k = 0;
    while (busy !== 1'b0 && k < 20) begin
      @(negedge i_clock);
      k++;
    end
    `CHK(busy, 1'b0, "capture model stuck")
    repeat (3) @(negedge i_clock);
    `CHK(o_code_bits, e[5:0], "code")
    `CHK(o_overflow_bit, e[6], "overflow")
    `CHK(o_code_valid, 1'b1, "valid")
    `CHK(o_acquire_phase, m != 2'h2, "phase")
    `CHK(o_code_bits_oe, i_all_outputs_enable & ~i_data_enable_n, "code oe")
    `CHK(o_overflow_bit_oe, i_all_outputs_enable, "overflow oe")
    `CHK(o_droop_expired, 1'b0, "droop")
    last = e;
  endtask : convert
  initial begin
    i_clock = 1'b0;
    i_reset_n = 1'b0;
    i_clock_enable = 1'b1;
    i_phase_invert = 1'b0;
    i_comparators = 64'hffffffffffffffff;
    i_data_enable_n = 1'b0;
    i_all_outputs_enable = 1'b1;
    start = 1'b0;
    mode = 2'h0;
    void'($urandom(32'h06e0));
    repeat (12) @(negedge i_clock);
    `CHK(o_code_bits, 6'h00, "code in reset")
    i_reset_n <= 1'b1;
    @(negedge i_clock);
    `CHK(o_code_valid, 1'b0, "valid after reset")
    $display("test reset done");
    convert(0, 2'h1);
    convert(1, 2'h1);
    convert(32, 2'h2);
    convert(63, 2'h3);
    convert(64, 2'h0);
    $display("test corners done");
    repeat (40) convert($urandom_range(64, 0), 2'($urandom_range(3, 0)));
    $display("test random done");
    @(negedge i_clock);
    i_clock_enable <= 1'b0;
    i_comparators <= 64'hfffffffffffffe00;
    mode <= 2'h1;
    start <= 1'b1;
    @(negedge i_clock);
    start <= 1'b0;
    repeat (12) @(negedge i_clock);
    i_clock_enable <= 1'b1;
    repeat (3) @(negedge i_clock);
    `CHK(o_code_bits, last[5:0], "code held while disabled")
    $display("test clock enable done");
    convert(20, 2'h1);
    repeat (630) @(negedge i_clock);
    `CHK(o_droop_expired, 1'b1, "droop flag")
    convert(21, 2'h1);
    $display("test droop done");
    complete_run();
  end
  initial begin
    #100000;
    err_count++;
    $display("mismatch at %0t: watchdog", $time);
    complete_run();
  end
endmodule : testbench
